// ==== hw/current_autozero_readback.sv ====
`timescale 1ns/100ps
`include "readback_map.svh"
// ----------------------------------------------------------------
// readback command interpreter behind a 32-bit serial slave port
// ----------------------------------------------------------------
module current_autozero_readback (
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    input  wire logic                                 sclk,
    input  wire logic                                 cs_n,
    input  wire logic                                 mosi,
    output logic                                      miso,
    output logic                                      miso_oe_n,
    input  wire logic                                 align_in,
    input  wire logic                                 overvoltage_in,
    input  wire logic                                 az_low_done,
    input  wire logic                                 az_high_done,
    input  wire logic [`CHANNELS*`CALIB_W-1:0]        az_low_values,
    input  wire logic [`CHANNELS*`CALIB_W-1:0]        az_high_values,
    input  wire logic [`CHANNELS*`CURRENT_W-1:0]      channel_current,
    output logic                                      cmd_strobe,
    output logic [`FRAME_BITS-1:0]                    cmd_word
);
    import readback_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic align_s;
    logic over_s;

    pin_sync3 #(.RESET_LEVEL(1'b0)) u_sync_sclk (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (sclk),
        .level (sclk_s)
    );

    // select idles high so a reset never looks like a frame start
    pin_sync3 #(.RESET_LEVEL(1'b1)) u_sync_cs (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (cs_n),
        .level (cs_n_s)
    );

    pin_sync3 #(.RESET_LEVEL(1'b0)) u_sync_mosi (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (mosi),
        .level (mosi_s)
    );

    pin_sync3 #(.RESET_LEVEL(1'b0)) u_sync_align (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (align_in),
        .level (align_s)
    );

    pin_sync3 #(.RESET_LEVEL(1'b0)) u_sync_over (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (overvoltage_in),
        .level (over_s)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    core_state_t st;
    core_state_t next_st;

    // ----------------------------------------------------------------
    // command decode helpers
    // ----------------------------------------------------------------
    logic [4:0]                 rx_id;
    logic [1:0]                 rx_ch;
    logic                       frame_ok;
    logic                       is_current;
    logic                       is_autozero;
    logic [`CURRENT_W-1:0]      cur_sel;
    logic [`CALIB_W-1:0]        low_sel;
    logic [`CALIB_W-1:0]        high_sel;
    logic                       sclk_rise;
    logic                       sclk_fall;
    logic                       align_rise;

    // only id and channel are looked at; bit 31 and 23:0 play no part
    assign rx_id       = st.rx[`ID_HI:`ID_LO];
    assign rx_ch       = st.rx[`CH_HI:`CH_LO];
    assign frame_ok    = (st.bit_cnt == `BITCNT_W'(`FRAME_BITS));
    assign is_current  = frame_ok && (rx_id == `MSG_CURRENT);
    assign is_autozero = frame_ok && (rx_id == `MSG_AUTOZERO);

    // per-channel selection of measured and stored values
    assign cur_sel  = channel_current[rx_ch*`CURRENT_W +: `CURRENT_W];
    assign low_sel  = az_low_values[rx_ch*`CALIB_W +: `CALIB_W];
    assign high_sel = az_high_values[rx_ch*`CALIB_W +: `CALIB_W];

    // edges seen on the synchronised levels
    assign sclk_rise  = sclk_s && !st.sclk_prev;
    assign sclk_fall  = !sclk_s && st.sclk_prev;
    assign align_rise = align_s && !st.align_prev;

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st            = st;
        next_st.cmd_strobe = 1'b0;
        next_st.sclk_prev  = sclk_s;
        next_st.align_prev = align_s;

        // event latches: set always wins over a same-cycle clear
        if (align_rise) begin
            next_st.alignment_edge_latch = 1'b1;
        end
        if (az_low_done) begin
            next_st.calib_low_cm_done = 1'b1;
        end
        if (az_high_done) begin
            next_st.calib_high_cm_done = 1'b1;
        end
        if (over_s) begin
            next_st.overvoltage_latch = 1'b1;
        end

        case (st.phase)
            PHASE_IDLE: begin
                next_st.miso_oe_n = 1'b1;
                if (!cs_n_s) begin
                    // previous frame's reply goes out in this one
                    next_st.phase     = PHASE_SHIFT;
                    next_st.bit_cnt   = '0;
                    next_st.tx        = st.reply;
                    next_st.miso      = st.reply[`FRAME_BITS-1];
                    next_st.miso_oe_n = 1'b0;
                end
            end
            PHASE_SHIFT: begin
                if (cs_n_s) begin
                    next_st.phase     = PHASE_IDLE;
                    next_st.miso_oe_n = 1'b1;
                    if (is_current) begin
                        next_st.reply = {1'b0, rx_id, rx_ch,
                                         `CUR_PAD_W'(0), cur_sel};
                    end else if (is_autozero) begin
                        next_st.reply = {1'b0, rx_id, rx_ch,
                                         `AZ_PAD_W'(0),
                                         st.overvoltage_latch,
                                         st.alignment_edge_latch,
                                         st.calib_low_cm_done,
                                         st.calib_high_cm_done,
                                         low_sel, high_sel};
                        // reading clears unless the event recurs now
                        if (!over_s) begin
                            next_st.overvoltage_latch = 1'b0;
                        end
                        if (!align_rise) begin
                            next_st.alignment_edge_latch = 1'b0;
                        end
                        if (!az_low_done) begin
                            next_st.calib_low_cm_done = 1'b0;
                        end
                        if (!az_high_done) begin
                            next_st.calib_high_cm_done = 1'b0;
                        end
                    end else if (frame_ok) begin
                        // other messages are handed on, reply shows the id only
                        next_st.reply      = {1'b0, rx_id, 26'h0000000};
                        next_st.cmd_strobe = 1'b1;
                        next_st.cmd_word   = st.rx;
                    end
                end else begin
                    if (sclk_rise && st.bit_cnt != `BITCNT_W'(`FRAME_BITS)) begin
                        next_st.rx      = {st.rx[`FRAME_BITS-2:0], mosi_s};
                        next_st.bit_cnt = st.bit_cnt + `BITCNT_W'(1);
                    end
                    if (sclk_fall) begin
                        next_st.tx   = {st.tx[`FRAME_BITS-2:0], 1'b0};
                        next_st.miso = st.tx[`FRAME_BITS-2];
                    end
                end
            end
            default: begin
                next_st.phase = PHASE_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    // reply starts at zero, so the first frame returns all-zero data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st           <= '0;
            st.phase     <= PHASE_IDLE;
            st.reply     <= `REPLY_RESET;
            st.miso_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all from flip-flops
    // ----------------------------------------------------------------
    assign miso       = st.miso;
    assign miso_oe_n  = st.miso_oe_n;
    assign cmd_strobe = st.cmd_strobe;
    assign cmd_word   = st.cmd_word;
endmodule // current_autozero_readback

// ==== hw/readback_map.svh ====
// Notes on behaviour
// - bit 31 write flag treated as read
// - id 01010 in 30:26, channel in 25:24
// - current reply: 0, echo id/channel, 23:14 zero
// - current is unsigned 14-bit code in 13:0
// - id 01011 selects autozero readback with channel
// - autozero reply: 0, echo id/channel, 23:16 zero
// - overvoltage latch bit 15, clears when low and read
// - alignment edge latch bit 14, cleared on read
// - low common-mode autozero done, bit 13
// - high common-mode autozero done, bit 12
// - calibration values low 11:6, high 5:0
// - reply low 24 bits zero after reset
`ifndef READBACK_MAP_SVH
`define READBACK_MAP_SVH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define FRAME_BITS        32
`define BITCNT_W          6
`define RW_BIT            31
`define ID_HI             30
`define ID_LO             26
`define CH_HI             25
`define CH_LO             24
`define CHANNELS          4

// ----------------------------------------------------------------
// message identifiers
// ----------------------------------------------------------------
`define MSG_CURRENT       5'h0a
`define MSG_AUTOZERO      5'h0b

// ----------------------------------------------------------------
// reply fields
// ----------------------------------------------------------------
`define CURRENT_W         14
`define CUR_PAD_W         10
`define AZ_PAD_W          8
`define OVER_LATCH_BIT    15
`define ALIGN_BIT         14
`define LOW_DONE_BIT      13
`define HIGH_DONE_BIT     12
`define CALIB_W           6
`define REPLY_RESET       32'h00000000

`endif

// ==== hw/readback_pkg.sv ====
package readback_pkg;

`include "readback_map.svh"

    // ----------------------------------------------------------------
    // frame phase and state records
    // ----------------------------------------------------------------
    typedef enum logic {
        PHASE_IDLE,
        PHASE_SHIFT
    } frame_phase_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } sync_state_t;

    typedef struct packed {
        frame_phase_t              phase;
        logic                      sclk_prev;
        logic                      align_prev;
        logic [`BITCNT_W-1:0]      bit_cnt;
        logic [`FRAME_BITS-1:0]    rx;
        logic [`FRAME_BITS-1:0]    tx;
        logic [`FRAME_BITS-1:0]    reply;
        logic                      overvoltage_latch;
        logic                      alignment_edge_latch;
        logic                      calib_low_cm_done;
        logic                      calib_high_cm_done;
        logic                      miso;
        logic                      miso_oe_n;
        logic                      cmd_strobe;
        logic [`FRAME_BITS-1:0]    cmd_word;
    } core_state_t;

endpackage

// ==== hw/pin_sync3.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// three-stage pin synchroniser, level moves when stages 2 and 3 agree
// ----------------------------------------------------------------
module pin_sync3 #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);
    import readback_pkg::*;

    sync_state_t st;
    sync_state_t next_st;

    // stage 1 feeds only stage 2; filter looks at stages 2 and 3
    always_comb begin
        next_st    = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st <= '{s1: RESET_LEVEL, s2: RESET_LEVEL, s3: RESET_LEVEL,
                    level: RESET_LEVEL};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.level;
endmodule // pin_sync3

// ==== tb/readback_sva.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port checker for the readback interpreter
// ----------------------------------------------------------------
module readback_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        sclk,
    input wire logic        cs_n,
    input wire logic        miso,
    input wire logic        miso_oe_n,
    input wire logic        cmd_strobe,
    input wire logic [31:0] cmd_word
);
    logic first;
    logic oe_q;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // first frame after reset still carries the all-zero reset reply
    always_ff @(posedge clk) begin
        oe_q <= miso_oe_n;
        if (!nrst) begin
            first <= 1'b1;
        end else if (miso_oe_n && !oe_q) begin
            first <= 1'b0;
        end
    end
    property p_rst_quiet;
        $rose(nrst) |-> miso_oe_n && !miso && !cmd_strobe && cmd_word == 32'h0;
    endproperty
    property p_first; first && !miso_oe_n |-> !miso; endproperty
    property p_msb; $fell(miso_oe_n) |-> !miso; endproperty
    property p_oe_on; (!cs_n) [*6] |-> !miso_oe_n; endproperty
    property p_oe_off; cs_n [*6] |-> miso_oe_n; endproperty
    property p_strobe_id; cmd_strobe |-> cmd_word[30:26] != 5'h0a && cmd_word[30:26] != 5'h0b;
    endproperty
    property p_strobe_end; cmd_strobe |-> cs_n && $past(cs_n, 3); endproperty
    // miso may only move a few clk after an sclk fall, never mid high phase
    property p_shift;
        !miso_oe_n && !$past(miso_oe_n) && $changed(miso) |-> !$past(sclk, 3);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    a_first: assert property (p_first) else $error("reset reply not zero");
    a_msb: assert property (p_msb) else $error("reply bit 31 set");
    a_oe_on: assert property (p_oe_on) else $error("miso not driven in frame");
    a_oe_off: assert property (p_oe_off) else $error("miso driven outside frame");
    a_strobe_id: assert property (p_strobe_id) else $error("readback id strobed");
    a_strobe_end: assert property (p_strobe_end) else $error("strobe inside frame");
    a_shift: assert property (p_shift) else $error("miso moved while sclk high");
    c_strobe: cover property (cmd_strobe);
    c_frame: cover property ($fell(miso_oe_n));
    c_one: cover property (!miso_oe_n && miso);
endmodule // readback_chk

bind current_autozero_readback readback_chk chk_i (
    .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .miso(miso),
    .miso_oe_n(miso_oe_n), .cmd_strobe(cmd_strobe), .cmd_word(cmd_word));

// ==== tb/spi_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------------------------------
// serial host model: sclk idle low, data moves after each fall
// ----------------------------------------------------------------
module spi_host (
    input  wire logic clk,
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso
);
    initial {sclk, cs_n, mosi} = 3'b011;
    // n bits msb first, half clk high, half+1 low; reply read late in the high
    // phase because the device moves miso some clk after each fall
    task automatic xfer(input logic [31:0] cmd, input int n, input int half,
                        output logic [31:0] rsp);
        rsp = 32'h0;
        @(posedge clk) cs_n <= 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            @(posedge clk) mosi <= cmd[i];
            repeat (half) @(posedge clk);
            sclk <= 1'b1;
            repeat (half) @(posedge clk);
            rsp = {rsp[30:0], miso};
            sclk <= 1'b0;
        end
        repeat (half) @(posedge clk);
        cs_n <= 1'b1;
        mosi <= ~mosi; // released line shows no stale data
        repeat (12) @(posedge clk); // gap well above 8 clk
    endtask
endmodule // spi_host

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        align_in = 1'b0;
    logic        overvoltage_in = 1'b0;
    logic        az_low_done = 1'b0;
    logic        az_high_done = 1'b0;
    logic [23:0] az_low_values = {6'h3f, 6'h2a, 6'h15, 6'h01};
    logic [23:0] az_high_values = {6'h00, 6'h3f, 6'h2b, 6'h10};
    logic [55:0] channel_current = {14'h3fff, 14'h2aaa, 14'h1234, 14'h0001};
    logic        sclk, cs_n, mosi, miso, miso_oe_n, cmd_strobe;
    logic [31:0] cmd_word, r, ex;
    int          n_tests = 0;
    int          n_mismatch = 0;
    // command beside the reply it earns one frame later
    logic [63:0] rows [9] = '{
        64'h28000000_28000001, 64'ha95a5a5a_29001234, 64'h2a000000_2a002aaa,
        64'h2bffffff_2b003fff, 64'h2c000000_2c000050, 64'had000000_2d00056b,
        64'hae123456_2e000abf, 64'h2f00ffff_2f000fc0, 64'h24abcdef_24000000};

    current_autozero_readback uut (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
        .miso_oe_n(miso_oe_n), .align_in(align_in), .overvoltage_in(overvoltage_in),
        .az_low_done(az_low_done), .az_high_done(az_high_done),
        .az_low_values(az_low_values), .az_high_values(az_high_values),
        .channel_current(channel_current), .cmd_strobe(cmd_strobe), .cmd_word(cmd_word));
    spi_host host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

    always #12.5 clk = ~clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t reply %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [31:0] cmd, input logic [31:0] exp);
        host.xfer(cmd, 32, 4, r);
        chk(r, exp);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        ex = 32'h0;
        // table, prompt and slow host in turn
        for (int i = 0; i < 9; i++) begin
            host.xfer(rows[i][63:32], 32, 4 + 4 * (i % 2), r);
            chk(r, ex);
            ex = rows[i][31:0];
        end
        // other ids are handed on whole, unused bits included
        chk(cmd_word, 32'h24abcdef);
        $display("table done");
        // all events while idle, overvoltage held high across reads
        {az_low_done, az_high_done, align_in, overvoltage_in} <= 4'hf;
        @(posedge clk) {az_low_done, az_high_done} <= 2'b00;
        repeat (6) @(posedge clk);
        frame(32'h2c000000, ex);
        align_in <= 1'b0;
        frame(32'h2c000000, 32'h2c00f050);
        overvoltage_in <= 1'b0;
        frame(32'h2c000000, 32'h2c008050);
        align_in <= 1'b1;
        frame(32'h28000000, 32'h2c008050);
        host.xfer(32'h2c000000, 16, 4, r); // short frame must change nothing
        frame(32'h2c000000, 32'h28000001);
        frame(32'h28000000, 32'h2c004050);
        align_in <= 1'b0;
        $display("events done");
        // second reset in mid-run
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        repeat (5) @(posedge clk);
        frame(32'h2c000000, 32'h0);
        frame(32'h2c000000, 32'h2c000050);
        $display("reset done");
        finish_test;
    end

    // about 6400 clk expected, so this only trips on a hang
    initial begin
        repeat (30000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        finish_test;
    end
endmodule // tb_top
